// [design/wwb_bridge_control.sv]
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Watchdog and its timebase stop while in sleep mode.
// - Window timing comes from the resistor-set internal oscillator tick.
// - After power-on, reset output stays low 68 ms, then goes high.
// - Reset time and lead time are fixed, independent of the timing resistor.
// - After reset release, wait up to 68 ms lead time for first edge.
// - No edge in lead time gives full reset, then lead time again.
// - Sequence is closed window then open window; valid triggers hit the open one.
// - Accepted trigger restarts the sequence at the closed window start.
// - Failed trigger gives a 2 ms reset, then the 68 ms lead time again.
// - Reset held while logic supply is below threshold.
// - Bridge enable needs sync, supply in range, pump good, no severe overheat.
// - Bridge enable low turns all four gates off.
// - Direction 0 drives half B with PWM; direction 1 swaps halves.
// - PWM duty and frequency pass through unchanged.
// - Short persisting 10 us switches the affected transistor off.
// - Non-overlap delay between turning one transistor off and partner on.
// - Diag two shows pump, over or under voltage; three temp warn; one shorts.
// - Diag one shows wake source until the first valid trigger.
// - High on either enable input requests activation.
// - Next PWM transition clears short flag and re-enables selected drivers.
// - High-voltage enable debounced 20 us on a 100 kHz clock.
module wwb_bridge_control
   import wwb_pkg::*;
#(
   parameter int RESET_CYC      = RESET_CYCLES,
   parameter int LEAD_CYC       = LEAD_CYCLES,
   parameter int SHORT_RST_CYC  = SHORT_RESET_CYCLES,
   parameter int OSC_DIV        = OSC_DIV_CYCLES,
   parameter int CLOSED_TICKS   = CLOSED_WINDOW_TICKS,
   parameter int OPEN_TICKS     = OPEN_WINDOW_TICKS,
   parameter int SHORT_DEB_CYC  = SHORT_DEB_CYCLES,
   parameter int DEAD_CYC       = 4
) (
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic wdog_trigger_in,
   input  wire logic logic_enable_in,
   input  wire logic hv_enable_in,
   input  wire logic lin_wake_in,
   input  wire logic sleep_request,
   input  wire logic supply_low_in,
   input  wire logic direction_in,
   input  wire logic pwm_in,
   input  wire logic batt_under_flag,
   input  wire logic batt_not_over_n,
   input  wire logic pump_good_flag,
   input  wire logic temp_warn_flag,
   input  wire logic temp_shutdown_flag,
   input  wire logic [3:0] short_detect_in,
   output var  logic reset_out_n,
   output var  logic activate_request,
   output var  logic bridge_enable,
   output var  logic high_gate_a,
   output var  logic low_gate_a,
   output var  logic high_gate_b,
   output var  logic low_gate_b,
   output var  logic diag_out_short_wake,
   output var  logic diag_out_supply_fault,
   output var  logic diag_out_temp_warn
);

   // ****************************************************************
   // Input synchronisers.
   // ****************************************************************
   logic wdogLevel;
   logic hvLevel;
   logic enLevel;
   logic linLevel;
   logic sleepLevel;
   logic supplyLow;
   logic dirLevel;
   logic pwmLevel;
   logic filterTick;
   logic [7:0] filterDiv;
   logic [7:0] next_filterDiv;

   // Divider giving the 100 kHz filter clock as an enable pulse.
   always_comb begin
      next_filterDiv = filterDiv + 8'h01;
      if (filterDiv >= 8'(FILTER_DIV_CYCLES - 1)) begin
         next_filterDiv = 8'h00;
      end
   end
   assign filterTick = (filterDiv == 8'h00);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         filterDiv <= 8'h00;
      end else begin
         filterDiv <= next_filterDiv;
      end
   end

   wwb_sync_filter #(.FILTER_TICKS(0)) syncWdog (.clock(clock), .reset_n(reset_n), .tick(1'b0),
      .pinIn(wdog_trigger_in), .level(wdogLevel));
   wwb_sync_filter #(.FILTER_TICKS(HV_FILTER_TICKS)) syncHv (.clock(clock), .reset_n(reset_n),
      .tick(filterTick), .pinIn(hv_enable_in), .level(hvLevel));
   wwb_sync_filter #(.FILTER_TICKS(0)) syncEn (.clock(clock), .reset_n(reset_n), .tick(1'b0),
      .pinIn(logic_enable_in), .level(enLevel));
   wwb_sync_filter #(.FILTER_TICKS(0)) syncLin (.clock(clock), .reset_n(reset_n), .tick(1'b0),
      .pinIn(lin_wake_in), .level(linLevel));
   wwb_sync_filter #(.FILTER_TICKS(0)) syncSleep (.clock(clock), .reset_n(reset_n), .tick(1'b0),
      .pinIn(sleep_request), .level(sleepLevel));
   wwb_sync_filter #(.FILTER_TICKS(0)) syncSupply (.clock(clock), .reset_n(reset_n), .tick(1'b0),
      .pinIn(supply_low_in), .level(supplyLow));
   wwb_sync_filter #(.FILTER_TICKS(0)) syncDir (.clock(clock), .reset_n(reset_n), .tick(1'b0),
      .pinIn(direction_in), .level(dirLevel));
   wwb_sync_filter #(.FILTER_TICKS(0)) syncPwm (.clock(clock), .reset_n(reset_n), .tick(1'b0),
      .pinIn(pwm_in), .level(pwmLevel));

   // Either enable high asks for activation.
   assign activate_request = enLevel | hvLevel;

   // ****************************************************************
   // Watchdog.
   // ****************************************************************
   wwb_state_type state;
   wwb_state_type next_state;
   logic [23:0] timer;
   logic [23:0] next_timer;
   logic [15:0] oscDiv;
   logic [15:0] next_oscDiv;
   logic        wdogPrev;
   logic        sync;
   logic        next_sync;
   logic        wakeLin;
   logic        next_wakeLin;
   logic        wakeHeld;
   logic        next_wakeHeld;
   logic        trigEdge;
   logic        oscTick;

   assign trigEdge = wdogLevel & ~wdogPrev;
   assign oscTick  = (oscDiv == 16'h0000);

   // Resistor-set oscillator tick; only window timing counts these.
   always_comb begin
      next_oscDiv = oscDiv - 16'h0001;
      if (oscDiv == 16'h0000 || state == WWB_SLEEP) begin
         next_oscDiv = 16'(OSC_DIV - 1);
      end
   end

   // Reset, lead, closed and open phases; a short reset uses SHORT_RST_CYC.
   always_comb begin
      next_state    = state;
      next_timer    = timer;
      next_sync     = sync;
      next_wakeLin  = wakeLin;
      next_wakeHeld = wakeHeld;
      unique case (state)
         WWB_SLEEP: begin
            next_timer = 24'(RESET_CYC - 1);
            if (activate_request | linLevel) begin
               next_state    = WWB_RESET;
               next_wakeLin  = linLevel & ~hvLevel;
               next_wakeHeld = 1'b1;
            end
         end
         WWB_RESET: begin
            next_sync = 1'b0;
            if (timer == 24'h000000) begin
               next_state = WWB_LEAD;
               next_timer = 24'(LEAD_CYC - 1);
            end else begin
               next_timer = timer - 24'h000001;
            end
         end
         WWB_LEAD: begin
            if (trigEdge) begin
               next_state    = WWB_CLOSED;
               next_timer    = 24'(CLOSED_TICKS - 1);
               next_sync     = 1'b1;
               next_wakeHeld = 1'b0;
            end else if (timer == 24'h000000) begin
               next_state = WWB_RESET;
               next_timer = 24'(RESET_CYC - 1);
            end else begin
               next_timer = timer - 24'h000001;
            end
         end
         WWB_CLOSED: begin
            if (trigEdge) begin
               next_state = WWB_RESET;
               next_timer = 24'(SHORT_RST_CYC - 1);
            end else if (oscTick) begin
               if (timer == 24'h000000) begin
                  next_state = WWB_OPEN;
                  next_timer = 24'(OPEN_TICKS - 1);
               end else begin
                  next_timer = timer - 24'h000001;
               end
            end
         end
         WWB_OPEN: begin
            if (trigEdge) begin
               next_state = WWB_CLOSED;
               next_timer = 24'(CLOSED_TICKS - 1);
            end else if (oscTick) begin
               if (timer == 24'h000000) begin
                  next_state = WWB_RESET;
                  next_timer = 24'(SHORT_RST_CYC - 1);
               end else begin
                  next_timer = timer - 24'h000001;
               end
            end
         end
      endcase
      // Sleep stops everything; supply loss restarts the long reset.
      if (sleepLevel && !enLevel) begin
         next_state = WWB_SLEEP;
         next_sync  = 1'b0;
      end else if (supplyLow && state != WWB_SLEEP) begin
         next_state = WWB_RESET;
         next_timer = 24'(RESET_CYC - 1);
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state    <= WWB_RESET;
         timer    <= 24'(RESET_CYC - 1);
         oscDiv   <= 16'h0000;
         wdogPrev <= 1'b0;
         sync     <= 1'b0;
         wakeLin  <= 1'b0;
         wakeHeld <= 1'b0;
      end else begin
         state    <= next_state;
         timer    <= next_timer;
         oscDiv   <= next_oscDiv;
         wdogPrev <= wdogLevel;
         sync     <= next_sync;
         wakeLin  <= next_wakeLin;
         wakeHeld <= next_wakeHeld;
      end
   end

   // Reset output registered so it cannot glitch.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reset_out_n <= 1'b0;
      end else begin
         reset_out_n <= (next_state != WWB_RESET) && (next_state != WWB_SLEEP) && !supplyLow;
      end
   end

   // ****************************************************************
   // Bridge drivers.
   // ****************************************************************
   logic       enableNow;
   logic [3:0] wantGate;
   logic [3:0] gate;
   logic [3:0] next_gate;
   logic [3:0] shortFault;
   logic [3:0] next_shortFault;
   logic [3:0] offCount [4];
   logic [3:0] next_offCount [4];
   logic [15:0] debCount [4];
   logic [15:0] next_debCount [4];
   logic       pwmPrev;

   assign enableNow = sync & ~batt_under_flag & batt_not_over_n & pump_good_flag
                      & ~temp_shutdown_flag;

   // Gate order: 0 high A, 1 low A, 2 high B, 3 low B.
   always_comb begin
      wantGate = 4'h0;
      if (enableNow) begin
         if (!dirLevel) begin
            wantGate = {pwmLevel, ~pwmLevel, 1'b0, 1'b1};
         end else begin
            wantGate = {1'b0, 1'b1, pwmLevel, ~pwmLevel};
         end
      end
   end

   // Per transistor: short debounce, fault latch and dead time before turn-on.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gateLane
         localparam int PARTNER = g ^ 1;
         always_comb begin
            next_shortFault[g] = shortFault[g];
            next_debCount[g]   = 16'h0000;
            next_offCount[g]   = offCount[g];
            next_gate[g]       = 1'b0;
            if (gate[g] && short_detect_in[g]) begin
               next_debCount[g] = debCount[g] + 16'h0001;
               if (debCount[g] >= 16'(SHORT_DEB_CYC - 1)) begin
                  next_shortFault[g] = 1'b1;
               end
            end
            if (pwmLevel != pwmPrev) begin
               next_shortFault[g] = 1'b0;
            end
            if (gate[PARTNER]) begin
               next_offCount[g] = 4'(DEAD_CYC);
            end else if (offCount[g] != 4'h0) begin
               next_offCount[g] = offCount[g] - 4'h1;
            end
            next_gate[g] = wantGate[g] & ~shortFault[g] & ~wantGate[PARTNER]
                           & (offCount[g] == 4'h0) & ~gate[PARTNER];
         end
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               shortFault[g] <= 1'b0;
               debCount[g]   <= 16'h0000;
               offCount[g]   <= 4'h0;
               gate[g]       <= 1'b0;
            end else begin
               shortFault[g] <= next_shortFault[g];
               debCount[g]   <= next_debCount[g];
               offCount[g]   <= next_offCount[g];
               gate[g]       <= next_gate[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pwmPrev <= 1'b0;
      end else begin
         pwmPrev <= pwmLevel;
      end
   end

   assign high_gate_a = gate[0];
   assign low_gate_a  = gate[1];
   assign high_gate_b = gate[2];
   assign low_gate_b  = gate[3];

   // ****************************************************************
   // Diagnostics, registered.
   // ****************************************************************
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bridge_enable         <= 1'b0;
         diag_out_short_wake   <= 1'b0;
         diag_out_supply_fault <= 1'b0;
         diag_out_temp_warn    <= 1'b0;
      end else begin
         bridge_enable         <= enableNow;
         diag_out_short_wake   <= wakeHeld ? wakeLin : (|shortFault);
         diag_out_supply_fault <= ~pump_good_flag | ~batt_not_over_n | batt_under_flag;
         diag_out_temp_warn    <= temp_warn_flag;
      end
   end

endmodule : wwb_bridge_control

`default_nettype wire

// [inc/wwb_pkg.sv]
package wwb_pkg;

   // ****************************************************************
   // Clock and timing constants.
   // ****************************************************************
   localparam int CLOCK_HZ            = 10000000;
   localparam int RESET_TIME_US       = 68000;
   localparam int LEAD_TIME_US        = 68000;
   localparam int SHORT_RESET_US      = 2000;
   localparam int SHORT_DEBOUNCE_US   = 10;
   localparam int HV_FILTER_US        = 20;
   localparam int FILTER_CLOCK_HZ     = 100000;
   // Oscillator ticks per window at the example resistor (12.32 us tick).
   localparam int CLOSED_WINDOW_TICKS = 982;
   localparam int OPEN_WINDOW_TICKS   = 780;
   localparam int OSC_PERIOD_NS       = 12320;

   // Derived cycle counts; least times round up.
   localparam int RESET_CYCLES        = (RESET_TIME_US * (CLOCK_HZ / 1000000));
   localparam int LEAD_CYCLES         = (LEAD_TIME_US * (CLOCK_HZ / 1000000));
   localparam int SHORT_RESET_CYCLES  = (SHORT_RESET_US * (CLOCK_HZ / 1000000));
   localparam int SHORT_DEB_CYCLES    = (SHORT_DEBOUNCE_US * (CLOCK_HZ / 1000000));
   localparam int FILTER_DIV_CYCLES   = CLOCK_HZ / FILTER_CLOCK_HZ;
   localparam int HV_FILTER_TICKS     = (HV_FILTER_US * FILTER_CLOCK_HZ + 999999) / 1000000;
   localparam int OSC_DIV_CYCLES      = (OSC_PERIOD_NS * (CLOCK_HZ / 1000000) + 999) / 1000;

   // Watchdog states.
   typedef enum logic [2:0] {
      WWB_SLEEP,
      WWB_RESET,
      WWB_LEAD,
      WWB_CLOSED,
      WWB_OPEN
   } wwb_state_type;

endpackage : wwb_pkg

// [design/wwb_sync_filter.sv]
`timescale 1ns/1ns
`default_nettype none

// Three-stage synchroniser with second/third agreement, plus optional
// hold-time filter counted in ticks of an enable pulse.
module wwb_sync_filter
   import wwb_pkg::*;
#(
   parameter int FILTER_TICKS = 0
) (
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic tick,
   input  wire logic pinIn,
   output var  logic level
);

   logic [2:0]  stage;
   logic        agreed;
   logic [15:0] holdCount;
   logic        next_agreed;
   logic [15:0] next_holdCount;
   logic        next_level;

   // ****************************************************************
   // Synchroniser and filter.
   // ****************************************************************

   // The first stage feeds only the second; agreement of two later stages.
   always_comb begin
      next_agreed    = agreed;
      next_holdCount = holdCount;
      next_level     = level;
      if (stage[1] == stage[2]) begin
         next_agreed = stage[2];
      end
      if (FILTER_TICKS == 0) begin
         next_level = agreed;
      end else if (agreed == level) begin
         next_holdCount = 16'h0000;
      end else if (tick) begin
         if (holdCount >= 16'(FILTER_TICKS - 1)) begin
            next_level     = agreed;
            next_holdCount = 16'h0000;
         end else begin
            next_holdCount = holdCount + 16'h0001;
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage     <= 3'h0;
         agreed    <= 1'b0;
         holdCount <= 16'h0000;
         level     <= 1'b0;
      end else begin
         stage     <= {stage[1:0], pinIn};
         agreed    <= next_agreed;
         holdCount <= next_holdCount;
         level     <= next_level;
      end
   end

endmodule : wwb_sync_filter

`default_nettype wire

// [tb/wwb_mcu_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Controller model: periodic watchdog trigger pulses.
// ****************************************************************
module wwb_mcu_model (
   input  wire logic clock,
   input  wire logic rstIn_n,
   input  var  int   period,
   output var  logic trigger
);
   int count = 0;

   // The pin rises once per period and stays high four cycles, long enough for the
   // synchroniser. A controller held in reset keeps the pin low and starts its
   // count again, so the first edge after release lands inside the lead time.
   always @(negedge clock) begin
      if (!rstIn_n || period == 0) begin
         count <= 0;
         trigger <= 1'h0;
      end else begin
         count <= (count >= period - 1) ? 0 : count + 1;
         trigger <= (count >= period - 4);
      end
   end
endmodule : wwb_mcu_model

`default_nettype wire

// [tb/wwb_bridge_control_asserts.sv]
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Port checker for the bridge controller.
// ****************************************************************
module wwb_bridge_control_asserts #(
   parameter int SHORT_RST_CYC = 50
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic logic_enable_in,
   input wire logic supply_low_in,
   input wire logic direction_in,
   input wire logic batt_under_flag,
   input wire logic batt_not_over_n,
   input wire logic pump_good_flag,
   input wire logic temp_shutdown_flag,
   input wire logic reset_out_n,
   input wire logic activate_request,
   input wire logic bridge_enable,
   input wire logic high_gate_a,
   input wire logic low_gate_a,
   input wire logic high_gate_b,
   input wire logic low_gate_b,
   input wire logic diag_out_short_wake,
   input wire logic diag_out_supply_fault
);
   logic [15:0] lowCnt;
   logic [15:0] next_lowCnt;

   // Length of the current reset pulse; no pulse comes near the counter's wrap.
   always_comb begin
      next_lowCnt = reset_out_n ? 16'h0 : lowCnt + 16'h1;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lowCnt <= 16'h0;
      end else begin
         lowCnt <= next_lowCnt;
      end
   end

   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   chk_gates_when_off: assert property (
      !bridge_enable [*3] |-> {high_gate_a, low_gate_a, high_gate_b, low_gate_b} == 4'h0)
      else $error("gate driven while bridge disabled");
   chk_enable_needs_status: assert property (
      (batt_under_flag || !batt_not_over_n || !pump_good_flag || temp_shutdown_flag) [*2] |-> !bridge_enable)
      else $error("bridge enabled with bad status");
   chk_sync_clears_reset: assert property (
      !reset_out_n [*3] |-> !bridge_enable)
      else $error("bridge enabled during watchdog reset");
   chk_supply_diag_set: assert property (
      (!pump_good_flag || batt_under_flag || !batt_not_over_n) [*2] |-> diag_out_supply_fault)
      else $error("supply fault not shown");
   chk_reset_min_len: assert property (
      $rose(reset_out_n) |-> lowCnt >= SHORT_RST_CYC - 1)
      else $error("reset pulse too short");
   chk_supply_holds_reset: assert property (
      supply_low_in [*8] |-> !reset_out_n)
      else $error("reset released with low supply");
   chk_dead_time_b: assert property (
      $rose(low_gate_b) |-> !$past(high_gate_b, 3))
      else $error("no dead time before low gate b");
   chk_forward_static: assert property (
      !direction_in [*8] ##1 (bridge_enable && !direction_in && !diag_out_short_wake) [*5]
      |-> (high_gate_a && !low_gate_a))
      else $error("half a wrong in direction zero");
   chk_activate_follows: assert property (
      logic_enable_in [*7] |-> activate_request)
      else $error("enable did not request activation");

   cover property ($rose(bridge_enable));
   cover property ($rose(diag_out_short_wake));
   cover property ($rose(reset_out_n) && lowCnt < 16'h64);
endmodule : wwb_bridge_control_asserts

bind wwb_bridge_control wwb_bridge_control_asserts #(.SHORT_RST_CYC(SHORT_RST_CYC)) chk_i (
   .clock(clock), .reset_n(reset_n), .logic_enable_in(logic_enable_in), .supply_low_in(supply_low_in),
   .direction_in(direction_in), .batt_under_flag(batt_under_flag), .batt_not_over_n(batt_not_over_n),
   .pump_good_flag(pump_good_flag), .temp_shutdown_flag(temp_shutdown_flag), .reset_out_n(reset_out_n),
   .activate_request(activate_request), .bridge_enable(bridge_enable), .high_gate_a(high_gate_a),
   .low_gate_a(low_gate_a), .high_gate_b(high_gate_b), .low_gate_b(low_gate_b),
   .diag_out_short_wake(diag_out_short_wake), .diag_out_supply_fault(diag_out_supply_fault)
);

`default_nettype wire

// [tb/tb_wwb_bridge_control.sv]
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Testbench for the bridge controller.
// ****************************************************************
module tb_wwb_bridge_control;
   localparam int RST  = 200;
   localparam int SRST = 50;
   logic       clock = 1'h0;
   logic       reset_n, logicEn, hvEn, direction, pwm, supplyLow, linWake, sleepReq;
   logic [4:0] stat;
   logic [3:0] shortIn;
   wire  [3:0] gates;
   wire        wdogPin, rstOut_n, actReq, bridgeEn, diagShort, diagSup, diagTemp;
   int         period, n;
   int         n_fail = 0;
   int         n_checks = 0;
   logic [3:0] gateExp [4] = '{4'ha, 4'h9, 4'ha, 4'h6};
   logic [4:0] faultSet [5] = '{5'h1c, 5'h04, 5'h08, 5'h0e, 5'h0d};
   logic [2:0] faultExp [5] = '{3'h2, 3'h2, 3'h2, 3'h5, 3'h0};

   // Short counts keep the run brief; the reset and lead time expectations are derived from them.
   wwb_bridge_control #(.RESET_CYC(RST), .LEAD_CYC(RST), .SHORT_RST_CYC(SRST), .OSC_DIV(2),
      .CLOSED_TICKS(10), .OPEN_TICKS(10), .SHORT_DEB_CYC(5)) wwb_bridge_control_i (
      .clock(clock), .reset_n(reset_n), .wdog_trigger_in(wdogPin), .logic_enable_in(logicEn),
      .hv_enable_in(hvEn), .lin_wake_in(linWake), .sleep_request(sleepReq), .supply_low_in(supplyLow),
      .direction_in(direction), .pwm_in(pwm), .batt_under_flag(stat[4]), .batt_not_over_n(stat[3]),
      .pump_good_flag(stat[2]), .temp_warn_flag(stat[1]), .temp_shutdown_flag(stat[0]),
      .short_detect_in(shortIn), .reset_out_n(rstOut_n), .activate_request(actReq),
      .bridge_enable(bridgeEn), .high_gate_a(gates[3]), .low_gate_a(gates[2]), .high_gate_b(gates[1]),
      .low_gate_b(gates[0]), .diag_out_short_wake(diagShort), .diag_out_supply_fault(diagSup),
      .diag_out_temp_warn(diagTemp));

   wwb_mcu_model wwb_mcu_model_i (.clock(clock), .rstIn_n(rstOut_n), .period(period), .trigger(wdogPin));

   // Free-running 10 MHz clock.
   always #50 clock = ~clock;

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask : cyc

   // Time the reset output stays at one level; capped so a stuck output cannot hang.
   task automatic span(input logic lvl, output int len);
      len = 0;
      while (rstOut_n === lvl && len < 600) begin
         @(negedge clock);
         len++;
      end
   endtask : span

   function automatic logic near(input int len, input int want);
      return (len >= want - 8 && len <= want + 8);
   endfunction : near

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // The sequence needs about 3500 cycles; the limit leaves nearly three times that.
   initial begin
      #1000000;
      n_fail++;
      close_out;
   end

   // Main sequence, all inputs moved at the falling edge.
   initial begin
      reset_n = 1'h0;
      {logicEn, hvEn, direction, pwm, supplyLow} = 5'h10;
      {linWake, sleepReq} = 2'h0;
      stat = 5'h0c;
      shortIn = 4'h0;
      period = 0;
      cyc(2);
      reset_n = 1'h1;
      span(1'h0, n);
      check("power-on reset", near(n, RST), 1'h1);
      check("enable before trigger", bridgeEn, 1'h0);
      span(1'h1, n);
      check("lead time", near(n, RST), 1'h1);
      span(1'h0, n);
      check("lead timeout reset", near(n, RST), 1'h1);
      period = 30;
      cyc(60);
      check("enable after trigger", bridgeEn, 1'h1);
      for (int i = 0; i < 4; i++) begin
         {direction, pwm} = i[1:0];
         cyc(12);
         check("gates", gates, gateExp[i]);
      end
      span(1'h1, n);
      check("open window kept", n == 600, 1'h1);
      {direction, pwm} = 2'h1;
      for (int i = 0; i < 5; i++) begin
         stat = faultSet[i];
         cyc(8);
         check("enable and diag", {bridgeEn, diagSup, diagTemp}, faultExp[i]);
         check("gates on fault", gates, faultExp[i][2] ? 4'h9 : 4'h0);
         stat = 5'h0c;
         cyc(12);
      end
      shortIn = 4'h1;
      cyc(15);
      check("short shutdown", {gates[3], diagShort}, 2'h1);
      shortIn = 4'h0;
      pwm = 1'h0;
      cyc(12);
      check("short cleared", {gates, diagShort}, 5'h14);
      period = 10;
      span(1'h1, n);
      period = 0;
      span(1'h0, n);
      check("closed window reset", near(n, SRST), 1'h1);
      check("sync after reset", bridgeEn, 1'h0);
      span(1'h1, n);
      check("lead after short reset", near(n, RST), 1'h1);
      span(1'h0, n);
      check("second lead timeout", near(n, RST), 1'h1);
      period = 30;
      cyc(45);
      period = 0;
      span(1'h1, n);
      check("open window expiry", n < 60, 1'h1);
      span(1'h0, n);
      check("missed trigger reset", near(n, SRST), 1'h1);
      logicEn = 1'h0;
      cyc(10);
      check("no activation", actReq, 1'h0);
      sleepReq = 1'h1;
      cyc(10);
      span(1'h0, n);
      check("sleep stops watchdog", n == 600, 1'h1);
      {sleepReq, linWake} = 2'h1;
      cyc(10);
      check("lin wake source", diagShort, 1'h1);
      span(1'h0, n);
      check("wake reset", near(n, RST), 1'h1);
      check("wake source held", diagShort, 1'h1);
      period = 30;
      cyc(40);
      check("wake source cleared", diagShort, 1'h0);
      hvEn = 1'h1;
      cyc(350);
      check("hv activation", actReq, 1'h1);
      supplyLow = 1'h1;
      cyc(10);
      check("supply low reset", rstOut_n, 1'h0);
      close_out;
   end
endmodule : tb_wwb_bridge_control

`default_nettype wire
